/* verilog/plp_loop.sv */
// pid loop with gain profiler and general parameter profiler
// assumes inputs come from logic on clk_sys and cycle_strobe is one cycle
`timescale 1ns/1ps
module plp_loop (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	input wire logic cycle_strobe,
	input wire plp_pkg::plp_val_t loop_input1,
	input wire plp_pkg::plp_val_t loop_input2,
	input wire plp_pkg::plp_val_t gain_x,
	input wire plp_pkg::plp_val_t curve_input_source,
	input wire plp_pkg::plp_val_t loop_clear,
	input wire plp_pkg::plp_val_t integrator_load,
	input wire logic [plp_pkg::ADDR_W-1:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	output plp_pkg::plp_val_t pid_out,
	output plp_pkg::plp_val_t prof_gain,
	output plp_pkg::plp_val_t prof_y,
	output logic out_valid
);
	import plp_pkg::*;

	function automatic logic signed [31:0] clip(
		input logic signed [63:0] v, input logic signed [63:0] lo,
		input logic signed [63:0] hi);
		if (v > hi)
			clip = 32'(hi);
		else if (v < lo)
			clip = 32'(lo);
		else
			clip = 32'(v);
	endfunction

	// curve between (xlo,ylo) and (xhi,yhi); t^n for n of 2 or more gives zero slope at xlo
	function automatic logic signed [31:0] curve(
		input logic [2:0] law, input logic signed [31:0] x,
		input logic signed [31:0] xlo, input logic signed [31:0] xhi,
		input logic signed [31:0] ylo, input logic signed [31:0] yhi);
		logic signed [63:0] t;
		logic signed [63:0] f;
		t = 64'sd0;
		f = 64'sd1 <<< CFRAC;
		if (law == 3'h0 || xlo >= xhi) begin // R15 R16
			curve = yhi;
		end else begin
			if (x <= xlo)
				t = 64'sd0;
			else if (x >= xhi)
				t = 64'sd1 <<< CFRAC;
			else
				t = (64'(x - xlo) <<< CFRAC) / 64'(xhi - xlo);
			for (int k = 1; k <= int'(LAW_MAX); k++) begin
				if (3'(k) <= law) // R17 R18
					f = (f * t) >>> CFRAC;
			end
			curve = ylo + 32'((64'(yhi - ylo) * f) >>> CFRAC);
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// settings written over the plain port

	plp_val_t cfg [0:NCFG-1];
	plp_val_t next_cfg [0:NCFG-1];

	always_comb begin
		for (int i = 0; i < NCFG; i++)
			next_cfg[i] = cfg[i];
		if (ce && wr && int'(addr) < NCFG) begin
			// laws beyond 4 clip so the selector stays 0..4
			if (addr == A_GAIN_LAW || addr == A_CURVE_LAW)
				next_cfg[addr] = (wdata > 16'(LAW_MAX)) ?
					16'(LAW_MAX) : wdata; // R12 R19
			else
				next_cfg[addr] = 16'(clip(64'(signed'(wdata)),
					-PCT_LIM, PCT_LIM)); // R14 R20
		end
	end

	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < NCFG; i++) begin
			if (!rstn)
				cfg[i] <= CFG_RST[i]; // R12 R19 R22 R23
			else
				cfg[i] <= next_cfg[i];
		end
	end

	////////////////////////////////////////////////////////////////////
	// loop arithmetic, evaluated on every strobe

	wire logic step = ce && cycle_strobe;
	wire logic clear_hi = (loop_clear != 16'h0000); // R24
	wire logic load_hi = (integrator_load != 16'h0000); // R24

	logic signed [31:0] integ;
	logic signed [31:0] filt;
	logic signed [31:0] err_prev;
	logic at_clamp;
	plp_val_t err_q;
	logic signed [31:0] next_integ;
	logic signed [31:0] next_filt;
	logic signed [31:0] next_err_prev;
	logic next_at_clamp;
	plp_val_t next_err_q;
	plp_val_t next_pid_out;
	plp_val_t next_prof_gain;
	plp_val_t next_prof_y;
	logic next_out_valid;

	logic signed [31:0] in2s;
	logic signed [31:0] err;
	logic signed [31:0] g;
	logic signed [31:0] ti;
	logic signed [31:0] td;
	logic signed [31:0] tf;
	logic signed [31:0] cpos;
	logic signed [31:0] cneg;
	logic signed [63:0] p;
	logic signed [63:0] d;
	logic signed [63:0] sum;
	logic signed [31:0] o;
	logic signed [31:0] gx;
	logic signed [31:0] cx;

	always_comb begin
		ti = 32'(unsigned'(cfg[A_INT_TIME]));
		td = 32'(unsigned'(cfg[A_DER_TIME]));
		tf = 32'(unsigned'(cfg[A_FLT_TIME]));
		cpos = 32'(cfg[A_CLAMP_POS]);
		cneg = 32'(cfg[A_CLAMP_NEG]);
		in2s = clip((64'(loop_input2) * 64'(cfg[A_IN2_SCALE])) /
			RATIO_ONE, -PCT_LIM, PCT_LIM); // R14
		err = clip(64'(in2s) - 64'(loop_input1),
			-ERR_LIM, ERR_LIM); // R11
		gx = (gain_x < 0) ? -32'(gain_x) : 32'(gain_x); // R13
		g = curve(cfg[A_GAIN_LAW][2:0], gx, 32'(cfg[A_GAIN_XMIN]),
			GP_XMAX, 32'(cfg[A_GAIN_MIN]), 32'(cfg[A_GAIN])); // R12
		cx = 32'(curve_input_source);
		if (cfg[A_ABS_EN] != 16'h0000 && cx < 0)
			cx = -cx; // R23
		// profiled gain is the proportional gain
		if (ti != 0) // R1 R26
			p = (64'(g) * 64'(err) * 64'(ti + td)) /
				(64'(GAIN_ONE) * 64'(ti));
		else
			p = (64'(g) * 64'(err)) / GAIN_ONE;
		if (td != 0) // R4
			d = (64'(g) * 64'(td) * 64'(err - err_prev)) / GAIN_ONE;
		else
			d = 64'sd0;

		next_integ = integ;
		next_filt = filt;
		next_err_prev = err_prev;
		next_at_clamp = at_clamp;
		next_err_q = err_q;
		next_pid_out = pid_out;
		next_prof_gain = prof_gain;
		next_prof_y = prof_y;
		next_out_valid = 1'b0;
		sum = 64'sd0;
		o = 32'sd0;
		if (step) begin // R25
			next_out_valid = 1'b1;
			next_err_prev = err;
			next_err_q = 16'(err);
			if (clear_hi) // R8 R9
				next_integ = 32'sd0;
			else if (load_hi) // R7
				next_integ = clip(64'(cfg[A_PRESET]) <<< IFRAC,
					64'(cneg) <<< IFRAC, 64'(cpos) <<< IFRAC);
			else if (at_clamp) // R2
				next_integ = integ;
			else if (ti != 0) // R3
				next_integ = clip(64'(integ) + (64'(g) * 64'(err) <<<
					IFRAC) / (64'(GAIN_ONE) * 64'(ti)),
					64'(cneg) <<< IFRAC, 64'(cpos) <<< IFRAC);
			sum = p + d + 64'(next_integ >>> IFRAC); // R6
			if (clear_hi) // R8
				next_filt = 32'sd0;
			else if (tf == 0) // R5
				next_filt = clip(sum <<< IFRAC, -64'sd2147483647,
					64'sd2147483647);
			else
				next_filt = clip(64'(filt) + ((sum <<< IFRAC) -
					64'(filt)) / (64'(tf) + 64'sd1),
					-64'sd2147483647, 64'sd2147483647);
			o = clip(64'(next_filt >>> IFRAC), cneg, cpos);
			next_at_clamp = !clear_hi && (o >= cpos || o <= cneg);
			next_pid_out = 16'(clip((64'(o) * 64'(cfg[A_TRIM])) /
				RATIO_ONE, -PCT_LIM, PCT_LIM)); // R10
			next_prof_gain = 16'(clip(64'(g), -PCT_LIM, PCT_LIM));
			next_prof_y = 16'(clip(64'(curve(cfg[A_CURVE_LAW][2:0], cx,
				32'(cfg[A_X_MIN]), 32'(cfg[A_X_MAX]),
				32'(cfg[A_Y_BOT]), 32'(cfg[A_Y_TOP]))),
				-PCT_LIM, PCT_LIM)); // R17 R21
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			integ <= 32'sd0;
			filt <= 32'sd0;
			err_prev <= 32'sd0;
			at_clamp <= 1'b0;
			err_q <= 16'h0000;
			pid_out <= 16'h0000;
			prof_gain <= 16'h0000;
			prof_y <= 16'h0000;
			out_valid <= 1'b0;
		end else if (ce) begin
			integ <= next_integ;
			filt <= next_filt;
			err_prev <= next_err_prev;
			at_clamp <= next_at_clamp;
			err_q <= next_err_q;
			pid_out <= next_pid_out;
			prof_gain <= next_prof_gain;
			prof_y <= next_prof_y;
			out_valid <= next_out_valid;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read port: data stand one cycle after the strobe only

	logic [15:0] next_rdata;

	always_comb begin
		next_rdata = 16'h0000;
		if (rd) begin
			if (int'(addr) < NCFG)
				next_rdata = cfg[addr];
			else if (addr == A_PID_OUT)
				next_rdata = pid_out;
			else if (addr == A_ERROR)
				next_rdata = err_q;
			else if (addr == A_PROF_GAIN)
				next_rdata = prof_gain;
			else if (addr == A_PROF_Y)
				next_rdata = prof_y;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn)
			rdata <= 16'h0000;
		else if (ce)
			rdata <= next_rdata;
	end

	////////////////////////////////////////////////////////////////////
	// checks

	a_clear_zero_out: assert property (@(posedge clk_sys) // R8
		disable iff (!rstn)
		step && clear_hi |=> pid_out == 16'h0000 && integ == 0)
		else $error("loop clear did not zero output and integrator");

	a_clear_filter: assert property (@(posedge clk_sys) // R8
		disable iff (!rstn)
		step && clear_hi |=> filt == 0 && !at_clamp)
		else $error("loop clear left filter or clamp flag set");

	a_clear_over_load: assert property (@(posedge clk_sys) // R9
		disable iff (!rstn)
		step && clear_hi && load_hi |=> integ == 0)
		else $error("integrator load won over loop clear");

	a_load_preset: assert property (@(posedge clk_sys) // R7
		disable iff (!rstn)
		step && load_hi && !clear_hi
		&& cfg[A_PRESET] <= cfg[A_CLAMP_POS]
		&& cfg[A_PRESET] >= cfg[A_CLAMP_NEG]
		|=> (integ >>> IFRAC) == 32'($past(cfg[A_PRESET])))
		else $error("integrator not loaded with preset");

	a_load_in_clamp: assert property (@(posedge clk_sys) // R3
		disable iff (!rstn)
		step && load_hi && !clear_hi
		&& cfg[A_CLAMP_NEG] <= cfg[A_CLAMP_POS]
		|=> (integ >>> IFRAC) <= 32'($past(cfg[A_CLAMP_POS])))
		else $error("loaded integrator above positive clamp");

	a_hold_at_clamp: assert property (@(posedge clk_sys) // R2
		disable iff (!rstn)
		step && at_clamp && !clear_hi && !load_hi |=> $stable(integ))
		else $error("integrator moved while output clamped");

	// a zero integral time is taken as integration switched off
	a_integ_no_time: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		step && !clear_hi && !load_hi && cfg[A_INT_TIME] == 16'h0000
		|=> $stable(integ))
		else $error("integrator moved with zero integral time");

	a_integ_in_clamp: assert property (@(posedge clk_sys) // R3
		disable iff (!rstn)
		step && !clear_hi && cfg[A_CLAMP_NEG] <= 0 && cfg[A_CLAMP_POS] >= 0
		##1 $stable(cfg[A_CLAMP_POS]) |->
		(integ >>> IFRAC) <= 32'(cfg[A_CLAMP_POS]))
		else $error("integrator above positive clamp");

	a_err_limit: assert property (@(posedge clk_sys) // R11
		disable iff (!rstn)
		err_q <= 16'(ERR_LIM) && err_q >= -16'(ERR_LIM))
		else $error("error outside 105 percent");

	a_trim_unity: assert property (@(posedge clk_sys) // R10
		disable iff (!rstn)
		step && cfg[A_TRIM] == 16'(RATIO_ONE)
		&& cfg[A_CLAMP_NEG] <= cfg[A_CLAMP_POS]
		|=> pid_out <= $past(cfg[A_CLAMP_POS])
		&& pid_out >= $past(cfg[A_CLAMP_NEG]))
		else $error("unity trim output outside clamps");

	a_law_range: assert property (@(posedge clk_sys) // R12 R19
		disable iff (!rstn)
		unsigned'(cfg[A_GAIN_LAW]) <= 16'(LAW_MAX)
		&& unsigned'(cfg[A_CURVE_LAW]) <= 16'(LAW_MAX))
		else $error("curve law selector above four");

	a_prof_law_zero: assert property (@(posedge clk_sys) // R16
		disable iff (!rstn)
		step && cfg[A_CURVE_LAW] == 16'h0000 |=> prof_y == $past(cfg[A_Y_TOP]))
		else $error("law zero profile not at top value");

	a_prof_x_order: assert property (@(posedge clk_sys) // R15
		disable iff (!rstn)
		step && cfg[A_X_MIN] >= cfg[A_X_MAX] |=>
		prof_y == $past(cfg[A_Y_TOP]))
		else $error("inverted x range not at top value");

	a_prof_range: assert property (@(posedge clk_sys) // R21
		disable iff (!rstn)
		prof_y <= 16'(PCT_LIM) && prof_y >= -16'(PCT_LIM))
		else $error("profiler output outside 300 percent");

	a_gain_range: assert property (@(posedge clk_sys) // R12
		disable iff (!rstn)
		prof_gain <= 16'(PCT_LIM) && prof_gain >= -16'(PCT_LIM))
		else $error("profiled gain outside 300 percent");

	a_idle_stable: assert property (@(posedge clk_sys) // R25
		disable iff (!rstn)
		ce && !cycle_strobe |=> $stable(pid_out) && $stable(integ) && !out_valid)
		else $error("loop changed without a strobe");

	a_valid_pulse: assert property (@(posedge clk_sys) // R25
		disable iff (!rstn)
		step |=> out_valid)
		else $error("no valid pulse after a strobe");

	// a low enable must freeze everything, the valid pulse included
	a_ce_freeze: assert property (@(posedge clk_sys) // R25
		disable iff (!rstn)
		!ce |=> $stable(pid_out) && $stable(out_valid) && $stable(integ)
		&& $stable(rdata))
		else $error("state moved while clock enable low");

	a_rdata_idle: assert property (@(posedge clk_sys)
		disable iff (!rstn)
		ce && !rd |=> rdata == 16'h0000)
		else $error("read data stood beyond one cycle");

	a_gain_law_zero: assert property (@(posedge clk_sys) // R12
		disable iff (!rstn)
		step && cfg[A_GAIN_LAW] == 16'h0000 |=>
		prof_gain == $past(cfg[A_GAIN]))
		else $error("law zero gain not at maximum gain");

endmodule

/* verilog/plp_pkg.sv */
// constants, register map and reset values for the pid loop with profiler
// assumes one clock, synchronous reset and a processing strobe from logic
// Functional notes
// R1 - proportional term is gain times (1+Td/Ti) times error
// R2 - integrator freezes while output sits at clamp
// R3 - clamp levels also limit the integrator
// R4 - zero derivative time removes derivative term
// R5 - zero filter time passes sum unchanged
// R6 - filter acts on the P+I+D sum
// R7 - integrator load forces integrator to preset
// R8 - loop clear zeroes output stage and integrator
// R9 - loop clear wins over integrator load
// R10 - signed trim scales and may invert output
// R11 - error limited to plus/minus 105 percent
// R12 - gain curve law 0..4, default 0
// R13 - gain profile input is rectified
// R14 - input 2 scaled by ratio, default 1
// R15 - Xmin at or above Xmax gives Y at top
// R16 - curve law 0 gives Y at top
// R17 - laws 1..4 linear to fourth power
// R18 - higher laws start with zero slope
// R19 - profiler curve law defaults to zero
// R20 - Y at bottom within 300 percent, default 0
// R21 - profiler output saturates at 300 percent
// R22 - Y at top defaults to 100 percent
// R23 - profiler rectify option, default set
// R24 - nonzero control value reads as high
// R25 - one update per processing strobe
// R26 - profiled gain drives proportional term
package plp_pkg;
	// percent in hundredths, ratio in ten-thousandths, times in strobes
	typedef logic signed [15:0] plp_val_t;
	localparam int ADDR_W = 5;
	localparam int NCFG = 18;
	localparam logic [4:0] A_GAIN = 5'h00;
	localparam logic [4:0] A_GAIN_MIN = 5'h01;
	localparam logic [4:0] A_INT_TIME = 5'h02;
	localparam logic [4:0] A_DER_TIME = 5'h03;
	localparam logic [4:0] A_FLT_TIME = 5'h04;
	localparam logic [4:0] A_PRESET = 5'h05;
	localparam logic [4:0] A_CLAMP_POS = 5'h06;
	localparam logic [4:0] A_CLAMP_NEG = 5'h07;
	localparam logic [4:0] A_TRIM = 5'h08;
	localparam logic [4:0] A_IN2_SCALE = 5'h09;
	localparam logic [4:0] A_GAIN_LAW = 5'h0a;
	localparam logic [4:0] A_GAIN_XMIN = 5'h0b;
	localparam logic [4:0] A_CURVE_LAW = 5'h0c;
	localparam logic [4:0] A_Y_BOT = 5'h0d;
	localparam logic [4:0] A_Y_TOP = 5'h0e;
	localparam logic [4:0] A_X_MIN = 5'h0f;
	localparam logic [4:0] A_X_MAX = 5'h10;
	localparam logic [4:0] A_ABS_EN = 5'h11;
	localparam logic [4:0] A_PID_OUT = 5'h12;
	localparam logic [4:0] A_ERROR = 5'h13;
	localparam logic [4:0] A_PROF_GAIN = 5'h14;
	localparam logic [4:0] A_PROF_Y = 5'h15;
	localparam logic [15:0] CFG_RST [0:NCFG-1] = '{
		16'h0064, 16'h0064, 16'h0064, 16'h0000, 16'h0000, 16'h0000,
		16'h2710, 16'hd8f0, 16'h2710, 16'h2710, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h2710, 16'h0000, 16'h2710, 16'h0001};
	localparam int PCT_LIM = 30000;
	localparam int ERR_LIM = 10500;
	localparam int RATIO_ONE = 10000;
	localparam int GAIN_ONE = 100;
	localparam int GP_XMAX = 10000;
	localparam logic [2:0] LAW_MAX = 3'h4;
	localparam int CFRAC = 14;
	localparam int IFRAC = 8;
endpackage

/* test/plp_src.sv */
// stand-in for the neighbouring drive blocks: feeds loop inputs, strobes
// assumes the loop samples every input at the edge that takes the strobe
`timescale 1ns/1ps
module plp_src (
	input wire logic clk_sys,
	output logic cycle_strobe,
	output plp_pkg::plp_val_t loop_input1,
	output plp_pkg::plp_val_t loop_input2,
	output plp_pkg::plp_val_t gain_x,
	output plp_pkg::plp_val_t curve_input_source
);
	import plp_pkg::*;
	initial begin
		cycle_strobe = 1'b0;
		loop_input1 = '0;
		loop_input2 = '0;
		gain_x = '0;
		curve_input_source = '0;
	end
	// values stay put after the strobe, as levels from other blocks do
	task automatic fire(input plp_val_t a, input plp_val_t b,
		input plp_val_t g, input plp_val_t c);
		@(posedge clk_sys);
		loop_input1 <= a;
		loop_input2 <= b;
		gain_x <= g;
		curve_input_source <= c;
		cycle_strobe <= 1'b1;
		@(posedge clk_sys);
		cycle_strobe <= 1'b0;
	endtask
endmodule

/* test/test_plp_loop.sv */
// self-checking bench for the pid loop with profiler
// assumes plp_src supplies strobes and data, bench drives registers
`timescale 1ns/1ps
module test_plp_loop;
	import plp_pkg::*;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic [4:0] addr = '0;
	logic [15:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	plp_val_t loop_clear = '0;
	plp_val_t integrator_load = '0;
	logic cycle_strobe;
	plp_val_t loop_input1, loop_input2, gain_x, curve_input_source;
	logic [15:0] rdata, v;
	plp_val_t pid_out, prof_gain, prof_y;
	logic out_valid;
	int mismatches = 0;
	int num_checks = 0;
	always #4 clk_sys = ~clk_sys;
	plp_src plp_src_i (.clk_sys(clk_sys), .cycle_strobe(cycle_strobe),
		.loop_input1(loop_input1), .loop_input2(loop_input2),
		.gain_x(gain_x), .curve_input_source(curve_input_source));
	plp_loop plp_loop_i (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
		.cycle_strobe(cycle_strobe), .loop_input1(loop_input1),
		.loop_input2(loop_input2), .gain_x(gain_x),
		.curve_input_source(curve_input_source), .loop_clear(loop_clear),
		.integrator_load(integrator_load), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .pid_out(pid_out),
		.prof_gain(prof_gain), .prof_y(prof_y), .out_valid(out_valid));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic step(input int a, input int b, input int g, input int c);
		plp_src_i.fire(16'(a), 16'(b), 16'(g), 16'(c));
		#1 chk("out_valid", {15'h0, out_valid}, 16'h0001);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		mismatches++;
		summarize();
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		for (int i = 0; i < NCFG; i++) begin
			rd_reg(5'(i), v);
			chk("cfg", v, CFG_RST[i]);
		end
		rd_reg(5'h1f, v);
		chk("unmapped", v, 16'h0000);
		step(0, 0, 0, 3000);
		chk("y law0", prof_y, 16'h2710);
		chk("gain law0", prof_gain, 16'h0064);
		@(posedge clk_sys);
		#1 chk("valid drop", {15'h0, out_valid}, 16'h0000);
		for (int law = 1; law <= 4; law++) begin
			wr_reg(A_CURVE_LAW, 16'(law));
			step(0, 0, 0, 5000);
			chk("y law", prof_y, 16'(10000 >> law));
		end
		wr_reg(A_CURVE_LAW, 16'h0001);
		step(0, 0, 0, -5000);
		chk("y rect", prof_y, 16'h1388);
		wr_reg(A_ABS_EN, 16'h0000);
		step(0, 0, 0, -5000);
		chk("y norect", prof_y, 16'h0000);
		wr_reg(A_ABS_EN, 16'h0001);
		wr_reg(A_X_MIN, 16'h4e20);
		step(0, 0, 0, 5000);
		chk("y xmin>xmax", prof_y, 16'h2710);
		wr_reg(A_X_MIN, 16'h0000);
		wr_reg(A_Y_TOP, 16'h7d00);
		wr_reg(A_Y_BOT, 16'h8300);
		rd_reg(A_Y_TOP, v);
		chk("ytop sat", v, 16'h7530);
		rd_reg(A_Y_BOT, v);
		chk("ybot sat", v, 16'h8ad0);
		wr_reg(A_Y_TOP, 16'h2710);
		wr_reg(A_GAIN, 16'h012c);
		wr_reg(A_GAIN_LAW, 16'h0001);
		step(0, 0, -5000, 0);
		chk("gain prof", prof_gain, 16'h00c8);
		wr_reg(A_GAIN_LAW, 16'h0000);
		wr_reg(A_GAIN, 16'h0064);
		wr_reg(A_INT_TIME, 16'h0000);
		step(0, 2000, 0, 0);
		chk("p only", pid_out, 16'h07d0);
		step(0, 20000, 0, 0);
		rd_reg(A_ERROR, v);
		chk("err lim", v, 16'h2904);
		chk("out clamp", pid_out, 16'h2710);
		wr_reg(A_TRIM, 16'hd8f0);
		step(0, 2000, 0, 0);
		chk("trim neg", pid_out, 16'hf830);
		wr_reg(A_TRIM, 16'h2710);
		wr_reg(A_IN2_SCALE, 16'h4e20);
		step(0, 1000, 0, 0);
		chk("in2 scale", pid_out, 16'h07d0);
		wr_reg(A_IN2_SCALE, 16'h2710);
		wr_reg(A_PRESET, 16'h0bb8);
		loop_clear <= 16'hffff;
		step(0, 2000, 0, 0);
		chk("clear", pid_out, 16'h0000);
		integrator_load <= 16'h0001;
		step(0, 0, 0, 0);
		step(0, 0, 0, 0);
		chk("clear wins", pid_out, 16'h0000);
		loop_clear <= 16'h0000;
		step(0, 0, 0, 0);
		step(0, 0, 0, 0);
		chk("load", pid_out, 16'h0bb8);
		integrator_load <= 16'h0000;
		step(0, 0, 0, 0);
		chk("hold", pid_out, 16'h0bb8);
		wr_reg(A_PRESET, 16'h3a98);
		integrator_load <= 16'h0001;
		step(0, 0, 0, 0);
		step(0, 0, 0, 0);
		chk("int clamp", pid_out, 16'h2710);
		integrator_load <= 16'h0000;
		loop_clear <= 16'h0001;
		step(0, 0, 0, 0);
		loop_clear <= 16'h0000;
		wr_reg(A_FLT_TIME, 16'h0001);
		step(0, 2000, 0, 0);
		chk("filter 1", pid_out, 16'h03e8);
		step(0, 2000, 0, 0);
		chk("filter 2", pid_out, 16'h05dc);
		// let the valid pulse drop first, a low enable freezes it
		@(posedge clk_sys);
		ce <= 1'b0;
		plp_src_i.fire(16'h0, 16'h0, 16'h0, 16'h0);
		#1 chk("ce low", {15'h0, out_valid}, 16'h0000);
		chk("ce hold", pid_out, 16'h05dc);
		ce <= 1'b1;
		wr_reg(A_FLT_TIME, 16'h0000);
		wr_reg(A_INT_TIME, 16'h0064);
		wr_reg(A_DER_TIME, 16'h0064);
		loop_clear <= 16'h0001;
		step(0, 0, 0, 0);
		@(posedge clk_sys);
		loop_clear <= 16'h0000;
		step(0, 100, 0, 0);
		chk("d kick", pid_out, 16'h2710);
		step(0, 100, 0, 0);
		chk("p with td", pid_out, 16'h00c9);
		step(0, 100, 0, 0);
		chk("integrate", pid_out, 16'h00ca);
		summarize();
	end
endmodule
